// ==== hdl/vpic_pkg.sv ====
// Contract
// - normal line from sources 1..31 only
// - three-bit priority per source, 7 most urgent
// - assert normal line on any matching condition
// - vector read picks highest pending enabled source
// - equal priority: smallest source number wins
// - in service: only higher priority asserts line
// - higher priority during service reasserts line
// - vector read pushes number and level
// - stack holds eight nested services
// - vector read returns selected source vector
// - vector register at fixed absolute address
// - vector read deasserts the normal line
// - vector read clears selected edge source
// - end-of-service write pops the stack
// - after pop, higher pending reasserts line
// - vector read is the acknowledgement
// - trigger type selects level/edge and polarity
// - disabled sources ignored by resolver
// - no auto clear for fast-redirected sources
package vpic_pkg;
   // ==================================================================
   // sizes
   localparam int unsigned NSRC  = 32;          // source count incl. source 0
   localparam int unsigned NUM_W = 5;           // source number width
   localparam int unsigned LVL_W = 3;           // priority width
   localparam int unsigned DEP_W = 4;           // stack depth counter width
   localparam int unsigned STACK_DEPTH = 8;     // nesting levels

   // ==================================================================
   // register byte addresses
   localparam logic [31:0] ADDR_MODE_BASE = 32'hfffff000; // source_mode_reg[n]
   localparam logic [31:0] ADDR_VEC_BASE  = 32'hfffff080; // source_vector_reg[n]
   localparam logic [31:0] ADDR_IVR       = 32'hfffff100; // interrupt_vector
   localparam logic [31:0] ADDR_CUR       = 32'hfffff108; // current service status
   localparam logic [31:0] ADDR_PEND      = 32'hfffff10c; // pending image
   localparam logic [31:0] ADDR_MASK      = 32'hfffff110; // enable mask image
   localparam logic [31:0] ADDR_EN        = 32'hfffff120; // source_enable_cmd
   localparam logic [31:0] ADDR_DIS       = 32'hfffff124; // source_disable_cmd
   localparam logic [31:0] ADDR_EOS       = 32'hfffff130; // end_of_service_cmd
   localparam logic [31:0] ADDR_FORCE     = 32'hfffff140; // fast redirect mask

   // ==================================================================
   // mode register fields
   localparam int unsigned MODE_W        = 7;  // implemented mode bits
   localparam int unsigned MODE_PRIO_LSB = 0;  // source_priority [2:0]
   localparam int unsigned TRIG_EDGE_BIT = 5;  // trigger_type bit 0: edge
   localparam int unsigned TRIG_HIGH_BIT = 6;  // trigger_type bit 1: high/rising
   localparam logic [6:0]  MODE_RST      = 7'h40; // high level, priority 0
   localparam logic [31:0] VEC_RST       = 32'h00000000;
   localparam logic [31:0] IVR_NONE      = 32'h00000000; // no source pending
   localparam logic [31:0] SRC0_MASK     = 32'h00000001; // fast source bit
endpackage : vpic_pkg

// ==== hdl/vpic_stack_if.sv ====
`timescale 1ns/1ps
// carrier between the controller and its service stack
interface vpic_stack_if;
   logic                            push;     // store an entry
   logic                            pop;      // drop the top entry
   logic [vpic_pkg::NUM_W-1:0]      push_num; // source number pushed
   logic [vpic_pkg::LVL_W-1:0]      push_lvl; // level pushed
   logic [vpic_pkg::NUM_W-1:0]      top_num;  // current source number
   logic [vpic_pkg::LVL_W-1:0]      top_lvl;  // current level
   logic [vpic_pkg::DEP_W-1:0]      depth;    // entries held
   modport ctrl  (output push, pop, push_num, push_lvl, input top_num, top_lvl, depth);
   modport store (input push, pop, push_num, push_lvl, output top_num, top_lvl, depth);
endinterface : vpic_stack_if

// ==== hdl/vpic_stack.sv ====
`timescale 1ns/1ps
// ====================================================================
// service stack: registered top entry, push and pop
module vpic_stack #(
   parameter int unsigned DEPTH = vpic_pkg::STACK_DEPTH
) (
   input  wire logic    clk,
   input  wire logic    rstn,
   vpic_stack_if.store  sif
);
   localparam int unsigned EW = vpic_pkg::NUM_W + vpic_pkg::LVL_W; // entry width

   // refuse depths the counter cannot hold
   if (DEPTH < 1 || DEPTH > 15) begin : g_bad_depth
      $error("vpic_stack depth out of range");
   end

   typedef struct packed {
      logic [DEPTH-1:0][EW-1:0]    mem;   // entries, index 0 oldest
      logic [vpic_pkg::DEP_W-1:0]  depth; // entries held
      logic [EW-1:0]               top;   // copy of newest entry
   } vpic_stk_t;

   vpic_stk_t s_r;  // state
   vpic_stk_t s_nxt; // next state

   // ==================================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      if (sif.push && s_r.depth < vpic_pkg::DEP_W'(DEPTH)) begin
         s_nxt.mem[s_r.depth] = {sif.push_num, sif.push_lvl};
         s_nxt.top            = {sif.push_num, sif.push_lvl};
         s_nxt.depth          = s_r.depth + 4'h1;
      end else if (sif.pop && s_r.depth != 4'h0) begin
         s_nxt.depth = s_r.depth - 4'h1;
         s_nxt.top   = (s_r.depth > 4'h1) ? s_r.mem[s_r.depth - 4'h2] : '0;
      end
   end

   // ==================================================================
   // state register, empty after reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sif.top_num = s_r.top[EW-1:vpic_pkg::LVL_W];
   assign sif.top_lvl = s_r.top[vpic_pkg::LVL_W-1:0];
   assign sif.depth   = s_r.depth;
endmodule : vpic_stack

// ==== hdl/vpic_ctrl.sv ====
`timescale 1ns/1ps
// ====================================================================
// normal interrupt path: resolver, vectors, nesting, apb slave
module vpic_ctrl #(
   parameter int unsigned STACK_DEPTH = vpic_pkg::STACK_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [31:0] irq_src,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             normal_irq_n
);
   // refuse stack depths below one per priority level
   if (STACK_DEPTH < 8 || STACK_DEPTH > 15) begin : g_bad_depth
      $error("vpic_ctrl stack depth out of range");
   end

   typedef struct packed {
      logic [31:0]            sync1;  // first sync stage
      logic [31:0]            sync2;  // second sync stage
      logic [31:0]            prev;   // previous synced sample
      logic [31:0]            pend;   // edge memories
      logic [31:0]            en;     // enable mask
      logic [31:0]            force_; // fast redirect mask
      logic [31:0][6:0]       mode;   // source_mode_reg
      logic [31:0][31:0]      vec;    // source_vector_reg
      logic [31:0]            prdata; // read data
      logic                   ack;    // access answered next cycle
      logic                   err;    // unmapped access
      logic                   irq_n;  // normal_irq_n
   } vpic_st_t;

   vpic_st_t s_r;   // state
   vpic_st_t s_nxt; // next state

   vpic_stack_if sif ();

   // service stack
   vpic_stack #(.DEPTH(STACK_DEPTH)) u_stack (
      .clk  (clk),
      .rstn (rstn),
      .sif  (sif)
   );

   // ==================================================================
   // resolver: {found, level, number}
   function automatic logic [8:0] vpic_pick(input logic [31:0]      el,
                                            input logic [31:0][6:0] md);
      logic       ok;
      logic [2:0] bl;
      logic [4:0] bn;
      ok = 1'b0;
      bl = 3'h0;
      bn = 5'h00;
      // descending scan, ties fall to lower number
      for (int i = 31; i >= 1; i--) begin
         if (el[i] && (!ok || md[i][2:0] >= bl)) begin
            ok = 1'b1;
            bl = md[i][2:0];
            bn = 5'(i);
         end
      end
      return {ok, bl, bn};
   endfunction : vpic_pick

   logic [31:0] act;      // active condition now
   logic [31:0] act_p;    // active condition last cycle
   logic [31:0] is_edge;  // edge mode per source
   logic [31:0] pend_eff; // pending seen by resolver
   logic [31:0] elig;     // enabled, pending, normal path
   logic [31:0] clr;      // edge memory clears
   logic [8:0]  pick;     // resolver result
   logic        sel_ok;   // a source is selectable
   logic [2:0]  sel_lvl;  // its level
   logic [4:0]  sel_num;  // its number
   logic        in_svc;   // something in service
   logic        above;    // request beats current level
   logic        tie_bad;  // helper: better pick exists
   logic        acc;      // access phase
   logic        first;    // first access cycle
   logic        done;     // answered access cycle
   logic        ivr_hit;  // vector read taken
   logic        in_mode;  // mode window hit
   logic        in_vec;   // vector window hit
   logic [4:0]  idx;      // word index in window
   logic        mapped;   // address decodes

   // per-source trigger decode
   for (genvar g = 0; g < 32; g++) begin : g_src
      assign act[g]      = s_r.mode[g][vpic_pkg::TRIG_HIGH_BIT] ? s_r.sync2[g] : ~s_r.sync2[g];
      assign act_p[g]    = s_r.mode[g][vpic_pkg::TRIG_HIGH_BIT] ? s_r.prev[g] : ~s_r.prev[g];
      assign is_edge[g]  = s_r.mode[g][vpic_pkg::TRIG_EDGE_BIT];
      assign pend_eff[g] = is_edge[g] ? s_r.pend[g] : act[g];
   end

   // ==================================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      // synchronise pins
      s_nxt.sync1 = irq_src;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev  = s_r.sync2;
      // drop source 0, disabled and redirected
      elig    = pend_eff & s_r.en & ~s_r.force_ & ~vpic_pkg::SRC0_MASK;
      pick    = vpic_pick(elig, s_r.mode);
      sel_ok  = pick[8];
      sel_lvl = pick[7:5];
      sel_num = pick[4:0];
      in_svc  = sif.depth != 4'h0;
      above   = 1'b0;
      tie_bad = 1'b0;
      for (int i = 1; i < 32; i++) begin
         if (elig[i] && (!in_svc || s_r.mode[i][2:0] > sif.top_lvl)) begin
            above = 1'b1;
         end
         if (elig[i] && (s_r.mode[i][2:0] > sel_lvl ||
             (s_r.mode[i][2:0] == sel_lvl && 5'(i) < sel_num))) begin
            tie_bad = 1'b1;
         end
      end
      s_nxt.irq_n = ~above;
      // apb phases: one wait state
      acc     = psel && penable;
      first   = acc && !s_r.ack;
      done    = acc && s_r.ack;
      s_nxt.ack = first;
      idx     = paddr[6:2];
      in_mode = paddr[31:7] == vpic_pkg::ADDR_MODE_BASE[31:7];
      in_vec  = paddr[31:7] == vpic_pkg::ADDR_VEC_BASE[31:7];
      mapped  = in_mode || in_vec || paddr == vpic_pkg::ADDR_IVR ||
                paddr == vpic_pkg::ADDR_CUR || paddr == vpic_pkg::ADDR_PEND ||
                paddr == vpic_pkg::ADDR_MASK || paddr == vpic_pkg::ADDR_EN ||
                paddr == vpic_pkg::ADDR_DIS || paddr == vpic_pkg::ADDR_EOS ||
                paddr == vpic_pkg::ADDR_FORCE;
      if (first) begin
         s_nxt.err = !mapped;
      end
      ivr_hit      = first && !pwrite && paddr == vpic_pkg::ADDR_IVR;
      sif.push     = 1'b0;
      sif.pop      = 1'b0;
      sif.push_num = sel_num;
      sif.push_lvl = sel_lvl;
      clr          = 32'h00000000;
      // read data latched in the first access cycle
      if (first && !pwrite) begin
         if (in_mode) begin
            s_nxt.prdata = {25'h0, s_r.mode[idx]};
         end else if (in_vec) begin
            s_nxt.prdata = s_r.vec[idx];
         end else if (paddr == vpic_pkg::ADDR_CUR) begin
            s_nxt.prdata = {23'h0, in_svc, sif.top_lvl, sif.top_num};
         end else if (paddr == vpic_pkg::ADDR_PEND) begin
            s_nxt.prdata = pend_eff;
         end else if (paddr == vpic_pkg::ADDR_MASK) begin
            s_nxt.prdata = s_r.en;
         end else if (paddr == vpic_pkg::ADDR_FORCE) begin
            s_nxt.prdata = s_r.force_;
         end else if (ivr_hit && sel_ok) begin
            s_nxt.prdata = s_r.vec[sel_num];
         end else begin
            // no pick, command or unmapped word
            s_nxt.prdata = vpic_pkg::IVR_NONE;
         end
      end
      if (ivr_hit && sel_ok) begin
         sif.push = 1'b1;
         // edge memory of the pick cleared
         clr[sel_num] = is_edge[sel_num];
      end
      // writes take effect on the answered edge
      if (done && pwrite) begin
         if (in_mode) begin
            s_nxt.mode[idx] = pwdata[6:0];
         end else if (in_vec) begin
            s_nxt.vec[idx] = pwdata;
         end else if (paddr == vpic_pkg::ADDR_EN) begin
            s_nxt.en = s_r.en | pwdata;
         end else if (paddr == vpic_pkg::ADDR_DIS) begin
            s_nxt.en = s_r.en & ~pwdata;
         end else if (paddr == vpic_pkg::ADDR_FORCE) begin
            s_nxt.force_ = pwdata;
         end else if (paddr == vpic_pkg::ADDR_EOS) begin
            sif.pop = in_svc;
         end
      end
      // edge memory: set wins over clear
      s_nxt.pend = (s_r.pend & ~clr) | (is_edge & act & ~act_p);
   end

   // ==================================================================
   // state register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r       <= '0;
         s_r.mode  <= {32{vpic_pkg::MODE_RST}};
         s_r.vec   <= {32{vpic_pkg::VEC_RST}};
         s_r.irq_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata       = s_r.prdata;
   assign pready       = s_r.ack;
   assign pslverr      = s_r.ack && s_r.err;
   assign normal_irq_n = s_r.irq_n;

   // ==================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // idle state, watched through reset itself
   a_reset_line_high: assert property (@(posedge clk) disable iff (1'b0)
      !rstn |=> normal_irq_n && sif.depth == 4'h0)
      else $error("line or stack not idle after reset");

   a_pick_priority: assert property (ivr_hit && sel_ok |-> !tie_bad)
      else $error("resolver skipped a better source");

   // number and level of the pick pushed
   a_push_level: assert property (
      ivr_hit && sel_ok && sif.depth < 4'h8
      |=> sif.top_lvl == $past(sel_lvl) && sif.top_num == $past(sel_num) &&
          sif.depth == $past(sif.depth) + 4'h1)
      else $error("vector read did not push level");

   a_vector_data: assert property (ivr_hit && sel_ok |=> prdata == $past(s_r.vec[sel_num]))
      else $error("vector read returned wrong address");

   // empty read returns zero, pushes nothing
   a_empty_read: assert property (
      ivr_hit && !sel_ok |=> prdata == vpic_pkg::IVR_NONE && $stable(sif.depth))
      else $error("empty vector read changed state");

   // line released unless a higher pick waits
   a_read_release: assert property (
      ivr_hit && sel_ok |-> ##2 (normal_irq_n || $past(sel_ok && sel_lvl > sif.top_lvl)))
      else $error("line still low after vector read");

   // end of service pops one entry
   a_eos_pop: assert property (
      done && pwrite && paddr == vpic_pkg::ADDR_EOS && in_svc
      |=> sif.depth == $past(sif.depth) - 4'h1)
      else $error("end of service did not pop");

   // end of service on empty stack ignored
   a_eos_empty: assert property (
      done && pwrite && paddr == vpic_pkg::ADDR_EOS && !in_svc |=> sif.depth == 4'h0)
      else $error("end of service moved an empty stack");

   // pick above current level drives line
   a_line_cause: assert property (
      sel_ok && (!in_svc || sel_lvl > sif.top_lvl) |=> !normal_irq_n)
      else $error("line not asserted for higher request");

   // nothing above current level, line quiet
   a_line_quiet: assert property (
      !sel_ok || (in_svc && sel_lvl <= sif.top_lvl) |=> normal_irq_n)
      else $error("line asserted without higher request");

   // edge memory of the pick cleared
   a_edge_clear: assert property (
      ivr_hit && sel_ok && is_edge[sel_num] && !(act[sel_num] && !act_p[sel_num])
      |=> !s_r.pend[$past(sel_num)])
      else $error("edge source not cleared by vector read");

   a_enable_set: assert property (
      done && pwrite && paddr == vpic_pkg::ADDR_EN
      |=> (s_r.en & $past(pwdata)) == $past(pwdata))
      else $error("enable command left bits clear");

   a_disable_clear: assert property (
      done && pwrite && paddr == vpic_pkg::ADDR_DIS
      |=> (s_r.en & $past(pwdata)) == 32'h00000000)
      else $error("disable command left bits set");

   a_stack_bound: assert property (sif.depth <= 4'h8)
      else $error("stack deeper than eight");

   // answer one cycle after first access
   a_one_wait: assert property (first |-> !pready ##1 pready)
      else $error("bus answer timing broken");

   // main scenarios reached
   c_nested: cover property (sif.depth == 4'h2);
   c_full: cover property (sif.depth == 4'h8);
   c_eos: cover property (done && pwrite && paddr == vpic_pkg::ADDR_EOS);
   c_empty_read: cover property (ivr_hit && !sel_ok);
   c_tie: cover property (ivr_hit && sel_ok && $countones(elig) > 1);
endmodule : vpic_ctrl

// ==== dv/vpic_cpu_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// processor side: apb master and handler entry and exit
module vpic_cpu_model (
   input  wire logic        clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      paddr,
   output logic [31:0]      pwdata
);
   int waits; // edges waited in the access phase

   // idle bus from time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 32'h00000000;
      pwdata  = 32'h00000000;
   end

   // one transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      waits = 0;
      do begin
         @(posedge clk);
         waits++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep the old value
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask : xfer

   task automatic take(output logic [31:0] q);
      logic e;
      xfer(1'b0, vpic_pkg::ADDR_IVR, 32'h00000000, q, e);
   endtask : take

   task automatic finish(input int gap);
      logic [31:0] q;
      logic        e;
      repeat (gap) @(posedge clk);
      xfer(1'b1, vpic_pkg::ADDR_EOS, 32'h00000000, q, e);
   endtask : finish
endmodule : vpic_cpu_model

// ==== dv/vectored_priority_irq_ctrl_test.sv ====
`timescale 1ns/1ps
// ==========================================================
// bench: programs sources, services them through the cpu model
module vectored_priority_irq_ctrl_test;
   logic        clk;          // system clock
   logic        rstn;         // sync reset, active low
   logic [31:0] irq_src;      // source pins
   logic        psel;         // apb select
   logic        penable;      // apb enable
   logic        pwrite;       // apb direction
   logic [31:0] paddr;        // apb address
   logic [31:0] pwdata;       // apb write data
   logic [31:0] prdata;       // apb read data
   logic        pready;       // apb ready
   logic        pslverr;      // apb error
   logic        normal_irq_n; // normal line, active low
   int          err_count;    // mismatches
   int          comparisons;  // checks made

   vpic_ctrl dut (.clk(clk), .rstn(rstn), .irq_src(irq_src), .psel(psel), .penable(penable),
                  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                  .pready(pready), .pslverr(pslverr), .normal_irq_n(normal_irq_n));
   vpic_cpu_model cpu (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                       .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                       .pwdata(pwdata));

   // clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================================
   // helpers
   function automatic logic [31:0] vec(input int n);
      return 32'h0000a000 + 32'(n * 16);
   endfunction : vec
   // status image: in service, level, number
   function automatic logic [31:0] st(input int n, input int l);
      return {23'h0, 1'b1, 3'(l), 5'(n)};
   endfunction : st
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                     input logic [31:0] msk = 32'hffffffff);
      logic [31:0] q;
      logic        e;
      cpu.xfer(1'b0, a, 32'h00000000, q, e);
      chk(q & msk, exp);
      chk({31'h0, e}, 32'h00000000);
      chk(32'(cpu.waits), 32'h00000002);
   endtask : rd
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      cpu.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic mode(input int n, input logic [31:0] v);
      wr(vpic_pkg::ADDR_MODE_BASE + 32'(4 * n), v);
   endtask : mode
   // pin changes for two cycles, then back
   task automatic toggle2(input int n);
      logic v;
      v = irq_src[n];
      @(posedge clk);
      irq_src[n] <= ~v;
      repeat (2) @(posedge clk);
      irq_src[n] <= v;
   endtask : toggle2
   // line high after k settled samples
   task automatic hi(input int k);
      repeat (k) @(negedge clk);
      chk({31'h0, normal_irq_n}, 32'h00000001);
   endtask : hi
   task automatic wait_low;
      int i;
      for (i = 0; i < 20 && normal_irq_n !== 1'b0; i++) @(negedge clk);
      chk({31'h0, normal_irq_n}, 32'h00000000);
   endtask : wait_low
   task automatic take_chk(input int n);
      logic [31:0] q;
      cpu.take(q);
      chk(q, vec(n));
   endtask : take_chk
   task automatic close_out;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] q;
      logic        e;
      err_count   = 0;
      comparisons = 0;
      rstn        = 1'b0;
      irq_src     = 32'h00300000;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      hi(1);
      rd(vpic_pkg::ADDR_CUR, 32'h00000000);
      rd(vpic_pkg::ADDR_MODE_BASE + 32'h4, 32'h00000040);
      cpu.xfer(1'b0, 32'hfffff1fc, 32'h00000000, q, e);
      chk({31'h0, e}, 32'h00000001);
      // program vectors, nesting ladder and mixed sources
      for (int n = 1; n < 32; n++) wr(vpic_pkg::ADDR_VEC_BASE + 32'(4 * n), vec(n));
      for (int n = 1; n <= 8; n++) mode(n, 32'h00000060 + 32'(n - 1));
      mode(9, 32'h00000043);
      mode(10, 32'h00000063);
      mode(11, 32'h00000065);
      mode(12, 32'h00000067);
      mode(13, 32'h00000067);
      mode(20, 32'h00000025);
      mode(21, 32'h00000002);
      wr(vpic_pkg::ADDR_FORCE, 32'h00002000);
      wr(vpic_pkg::ADDR_EN, 32'h00302fff);
      rd(vpic_pkg::ADDR_MASK, 32'h00302fff);
      wr(vpic_pkg::ADDR_DIS, 32'h00000001);
      rd(vpic_pkg::ADDR_MASK, 32'h00302ffe);
      // source 0, disabled and redirected sources stay off the line
      @(posedge clk);
      irq_src[0] <= 1'b1;
      toggle2(12);
      toggle2(13);
      hi(12);
      rd(vpic_pkg::ADDR_IVR, vpic_pkg::IVR_NONE);
      rd(vpic_pkg::ADDR_PEND, 32'h00002000, 32'h00002000);
      @(posedge clk);
      irq_src[0] <= 1'b0;
      // eight nested services, each one level higher
      for (int n = 1; n <= 8; n++) begin
         toggle2(n);
         wait_low();
         take_chk(n);
         hi(1);
         rd(vpic_pkg::ADDR_CUR, st(n, n - 1));
      end
      rd(vpic_pkg::ADDR_PEND, 32'h00000000, 32'h000001fe);
      for (int n = 8; n >= 1; n--) begin
         rd(vpic_pkg::ADDR_CUR, st(n, n - 1));
         cpu.finish(0);
      end
      rd(vpic_pkg::ADDR_CUR, 32'h00000000, 32'h00000100);
      // lower and equal levels wait for the end of service
      toggle2(11);
      wait_low();
      take_chk(11);
      @(posedge clk);
      irq_src[9] <= 1'b1;
      toggle2(10);
      toggle2(20);
      hi(12);
      cpu.finish(3);
      wait_low();
      take_chk(20);
      cpu.finish(0);
      wait_low();
      take_chk(9);
      rd(vpic_pkg::ADDR_PEND, 32'h00000200, 32'h00000200);
      @(posedge clk);
      irq_src[9] <= 1'b0;
      cpu.finish(4);
      wait_low();
      take_chk(10);
      cpu.finish(0);
      @(posedge clk);
      irq_src[21] <= 1'b0;
      wait_low();
      take_chk(21);
      @(posedge clk);
      irq_src[21] <= 1'b1;
      cpu.finish(4);
      hi(12);
      cpu.finish(0);
      rd(vpic_pkg::ADDR_CUR, 32'h00000000);
      // reset in the middle of a service
      toggle2(11);
      wait_low();
      take_chk(11);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      hi(1);
      rd(vpic_pkg::ADDR_CUR, 32'h00000000);
      rd(vpic_pkg::ADDR_MASK, 32'h00000000);
      close_out();
   end
endmodule : vectored_priority_irq_ctrl_test
